// [logic/trm_fault_manager.sv]
// Thermal and drive-rail fault manager with regulator sequencing.
`timescale 1ns/1ps
`include "trm_regs.svh"

module trm_fault_manager
    import trm_pkg::*;
#(
    parameter int unsigned HICCUP_CYCLES = `TRM_HICCUP_CYC,
    parameter int unsigned SOFTSTART_CYCLES = `TRM_SOFTSTART_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable_in,
    input wire logic temp_warn,
    input wire logic temp_shutdown,
    input wire logic buck_peak_reached,
    input wire logic buck_current_limit,
    input wire logic buck_overcurrent,
    input wire logic drive_rail_under,
    input wire logic drive_rail_over,
    output logic fault_out_n,
    output logic gate_drive_en,
    output logic standby_reg_en,
    output logic standby_sw_on,
    output logic run_reg_en,
    output logic run_sw_on,
    output logic core_low_power,
    output logic buck_pwm,
    output logic pump_a,
    output logic pump_b
);
    localparam logic [21:0] HIC_LAST = 22'(HICCUP_CYCLES - 1);
    localparam logic [21:0] SS_LAST = 22'(SOFTSTART_CYCLES - 1);
    localparam logic [6:0] OSC_LAST = 7'(`TRM_OSC_DIV - 1);
    localparam logic [1:0] OC_LAST = 2'(`TRM_OC_DLY_CYC - 1);

    // Latched flag: a new event wins over a clear in the same cycle.
    function automatic logic keep(input logic flag, input logic set,
                                  input logic cond, input logic clr);
        keep = set | (flag & ~(clr & ~cond));
    endfunction : keep

    trm_ctrl_s ctrl_q;
    trm_flags_s flags_q;
    trm_flags_s flags_d;
    trm_buck_e buck_q;
    trm_buck_e buck_d;
    logic [21:0] tmr_q;
    logic [21:0] tmr_d;
    logic [1:0] oc_q;
    logic [1:0] oc_d;
    logic [6:0] osc_q;
    logic phase_q;
    logic en_q;
    logic sd_block_q;
    logic rail_pend_q;

    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire hit_ctrl = paddr == `TRM_CTRL_OFS;
    wire hit_stat = paddr == `TRM_STAT_OFS;
    wire ctrl_wr = access & pwrite & hit_ctrl;
    wire osc_tick = osc_q == OSC_LAST;
    wire clr_evt = (ctrl_wr & pwdata[`TRM_CTRL_CLEAR]) | (enable_in & ~en_q);
    wire sd_active = temp_shutdown & ~ctrl_q.shutdown_disable;
    wire buck_allowed = enable_in & ~sd_active;
    wire switching = (buck_q == BK_SOFT || buck_q == BK_RUN ||
                      buck_q == BK_OCDLY) & ~drive_rail_over;
    wire run_en = buck_q == BK_RUN & ~rail_pend_q;
    wire oc_cond = buck_overcurrent;
    wire any_rail = oc_cond | drive_rail_under | drive_rail_over;
    wire any_cond = any_rail | temp_shutdown;
    wire gate_ok = enable_in & ~sd_block_q & ~flags_q.buck_oc &
                   ~flags_q.uv & ~flags_q.ov;
    wire fault_cause = (flags_q.warn & ctrl_q.warn_report_en) |
                       temp_shutdown | rail_pend_q | drive_rail_over;
    wire pwm_cut = buck_peak_reached | buck_current_limit | buck_overcurrent;
    wire [31:0] rd_word = hit_ctrl ? {30'h0, ctrl_q} :
                          hit_stat ? {21'h0, fault_cause, run_en, 1'b0,
                                      gate_drive_en, flags_q} : 32'h0;

    always_comb begin
        flags_d.warn = temp_warn;
        flags_d.sd = keep(flags_q.sd, temp_shutdown, temp_shutdown,
                          clr_evt);
        flags_d.buck_oc = keep(flags_q.buck_oc, oc_cond, oc_cond,
                               clr_evt);
        flags_d.uv = keep(flags_q.uv, drive_rail_under, drive_rail_under,
                          clr_evt);
        flags_d.ov = keep(flags_q.ov, drive_rail_over, drive_rail_over,
                          clr_evt);
        flags_d.buck_fault = keep(flags_q.buck_fault, any_rail, any_rail,
                                  clr_evt);
        flags_d.global = keep(flags_q.global, any_cond, any_cond,
                              clr_evt);
    end

    // Buck sequencer: soft-start, run, delayed overcurrent stop, hiccup.
    always_comb begin
        buck_d = buck_q;
        tmr_d = tmr_q + 22'h1;
        oc_d = oc_q;
        if (!buck_allowed) begin
            buck_d = BK_OFF;
            tmr_d = 22'h0;
        end else begin
            unique case (buck_q)
                BK_OFF: begin
                    buck_d = BK_SOFT;
                    tmr_d = 22'h0;
                end
                BK_SOFT, BK_RUN: begin
                    if (drive_rail_under) begin
                        buck_d = BK_HICCUP;
                        tmr_d = 22'h0;
                    end else if (buck_overcurrent) begin
                        buck_d = BK_OCDLY;
                        oc_d = 2'h0;
                    end else if (buck_q == BK_SOFT && tmr_q == SS_LAST) begin
                        buck_d = BK_RUN;
                    end
                    if (buck_q == BK_RUN) begin
                        tmr_d = tmr_q;
                    end
                end
                BK_OCDLY: begin
                    if (osc_tick) begin
                        oc_d = oc_q + 2'h1;
                        if (oc_q == OC_LAST) begin
                            buck_d = BK_HICCUP;
                            tmr_d = 22'h0;
                        end
                    end
                end
                BK_HICCUP: begin
                    if (tmr_q == HIC_LAST) begin
                        buck_d = BK_SOFT;
                        tmr_d = 22'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~(hit_ctrl | hit_stat);
            prdata <= setup & ~pwrite ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TRM_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_q.warn_report_en <= pwdata[`TRM_CTRL_REPORT];
            ctrl_q.shutdown_disable <= pwdata[`TRM_CTRL_SDDIS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
            sd_block_q <= 1'b0;
            rail_pend_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            en_q <= enable_in;
            sd_block_q <= keep(sd_block_q, sd_active, temp_shutdown,
                               clr_evt);
            // Held until the rail has soft-started again.
            rail_pend_q <= (oc_cond | drive_rail_under) |
                           (rail_pend_q & ~(buck_q == BK_RUN));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buck_q <= BK_OFF;
            tmr_q <= 22'h0;
            oc_q <= 2'h0;
            osc_q <= 7'h0;
            phase_q <= 1'b0;
        end else begin
            buck_q <= buck_d;
            tmr_q <= tmr_d;
            oc_q <= oc_d;
            osc_q <= osc_tick ? 7'h0 : osc_q + 7'h1;
            phase_q <= phase_q ^ osc_tick;
        end
    end

    // The pulse opens on each oscillator tick while switching and ends at the first cut.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buck_pwm <= 1'b0;
            pump_a <= 1'b0;
            pump_b <= 1'b0;
        end else begin
            // A pulse must not open on the tick that enters hiccup.
            if (!switching || pwm_cut || buck_d == BK_HICCUP) begin
                buck_pwm <= 1'b0;
            end else if (osc_tick) begin
                buck_pwm <= 1'b1;
            end
            pump_a <= run_en & ~drive_rail_over & phase_q;
            pump_b <= run_en & ~drive_rail_over & ~phase_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_out_n <= 1'b1;
            gate_drive_en <= 1'b0;
            standby_reg_en <= 1'b1;
            standby_sw_on <= 1'b1;
            run_reg_en <= 1'b0;
            run_sw_on <= 1'b0;
            core_low_power <= 1'b1;
        end else begin
            fault_out_n <= ~fault_cause;
            gate_drive_en <= gate_ok;
            standby_reg_en <= ~run_en;
            standby_sw_on <= ~run_en;
            run_reg_en <= run_en;
            run_sw_on <= run_en;
            core_low_power <= ~enable_in;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_warn;
        (temp_warn |=> flags_q.warn) and (!temp_warn |=> !flags_q.warn);
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning flag did not follow comparator");

    property p_report;
        flags_q.warn && ctrl_q.warn_report_en |=> !fault_out_n;
    endproperty
    a_report: assert property (p_report)
        else $error("reported warning missing on fault output");

    property p_shutdown;
        (temp_shutdown && !ctrl_q.shutdown_disable)[*2] |=>
            !run_reg_en && standby_reg_en && !gate_drive_en && !pump_a;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("thermal shutdown actions missing");

    property p_sd_disabled;
        temp_shutdown && ctrl_q.shutdown_disable && buck_q == BK_RUN &&
            enable_in && !any_rail |=> buck_q == BK_RUN;
    endproperty
    a_sd_disabled: assert property (p_sd_disabled)
        else $error("state changed with shutdown disabled");

    property p_limit;
        buck_current_limit |=> !buck_pwm;
    endproperty
    a_limit: assert property (p_limit)
        else $error("current limit did not cut the pulse");

    property p_hiccup;
        buck_q == BK_HICCUP |-> !buck_pwm && !switching;
    endproperty
    a_hiccup: assert property (p_hiccup)
        else $error("pulse during hiccup");

    property p_uv;
        $rose(drive_rail_under) |=> flags_q.uv && flags_q.buck_fault &&
            flags_q.global;
    endproperty
    a_uv: assert property (p_uv)
        else $error("undervoltage flags not latched");

    property p_ov;
        drive_rail_over |=> !pump_a && !pump_b && !buck_pwm;
    endproperty
    a_ov: assert property (p_ov)
        else $error("switching not halted on overvoltage");

    property p_standby_sw;
        (standby_sw_on == standby_reg_en && run_sw_on == run_reg_en) and
            (buck_q != BK_RUN |=> standby_reg_en && !run_reg_en);
    endproperty
    a_standby_sw: assert property (p_standby_sw)
        else $error("selection switch does not follow regulator");

    property p_pump;
        !(pump_a && pump_b);
    endproperty
    a_pump: assert property (p_pump)
        else $error("pump pairs overlap");

    property p_clear;
        clr_evt && !any_cond |=> {flags_q.ov, flags_q.uv, flags_q.buck_oc,
            flags_q.buck_fault, flags_q.sd, flags_q.global} == 6'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not reset ended flags");

    property p_oc_latch;
        $rose(buck_overcurrent) |=> flags_q.buck_oc && flags_q.buck_fault &&
            flags_q.global;
    endproperty
    a_oc_latch: assert property (p_oc_latch)
        else $error("overcurrent flags not latched");

    property p_gate_hold;
        sd_block_q |=> !gate_drive_en;
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("gates enabled before shutdown was cleared");

    property p_run_rail;
        buck_q == BK_RUN && !rail_pend_q |=> run_reg_en && run_sw_on &&
            !standby_reg_en;
    endproperty
    a_run_rail: assert property (p_run_rail)
        else $error("run rail not selected after soft-start");

    // The enable history gate keeps the reset value out of the check.
    property p_core;
        (!enable_in |=> core_low_power) and
            (en_q && enable_in |=> !core_low_power);
    endproperty
    a_core: assert property (p_core)
        else $error("core regulator mode does not follow enable");

    property p_ov_end;
        $fell(drive_rail_over) && buck_q == BK_RUN && !rail_pend_q |=>
            pump_a || pump_b;
    endproperty
    a_ov_end: assert property (p_ov_end)
        else $error("pump did not resume after overvoltage");

    c_hiccup: cover property (buck_q == BK_OCDLY ##[1:200]
        buck_q == BK_HICCUP);
    c_ov_end: cover property ($fell(drive_rail_over));
    c_run: cover property ($rose(run_reg_en));
    c_shutdown: cover property ($rose(sd_block_q));
    c_clear: cover property (clr_evt && flags_q.global);
endmodule : trm_fault_manager

// [logic/trm_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef TRM_REGS_SVH
`define TRM_REGS_SVH
`define TRM_CTRL_OFS 12'h000
`define TRM_STAT_OFS 12'h004
`define TRM_CTRL_REPORT 0
`define TRM_CTRL_SDDIS 1
`define TRM_CTRL_CLEAR 2
`define TRM_CTRL_RST 2'h0
`define TRM_CLK_HZ 40000000
`define TRM_OSC_HZ 500000
`define TRM_OSC_DIV (`TRM_CLK_HZ / `TRM_OSC_HZ)
`define TRM_OC_DLY_CYC 2
`define TRM_HICCUP_MS 63
`define TRM_HICCUP_CYC (`TRM_HICCUP_MS * (`TRM_CLK_HZ / 1000))
`define TRM_SOFTSTART_US 1000
`define TRM_SOFTSTART_CYC (`TRM_SOFTSTART_US * (`TRM_CLK_HZ / 1000000))
`endif

// [logic/trm_pkg.sv]
// Types shared by the thermal and rail fault manager.
package trm_pkg;
    typedef enum logic [2:0] {
        BK_OFF, BK_SOFT, BK_RUN, BK_OCDLY, BK_HICCUP
    } trm_buck_e;
    typedef struct packed {
        logic ov;
        logic uv;
        logic buck_oc;
        logic buck_fault;
        logic sd;
        logic warn;
        logic global;
    } trm_flags_s;
    typedef struct packed {
        logic shutdown_disable;
        logic warn_report_en;
    } trm_ctrl_s;
endpackage : trm_pkg

// [verification/trm_ctrl_model.sv]
// Controller model that owns the enable pin of the fault manager.
`timescale 1ns/1ps
module trm_ctrl_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fault_out_n,
    input wire logic pulse_req,
    input wire logic cool_en,
    output logic enable_in
);
    logic [2:0] low_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 3'h0;
        end else if (pulse_req) begin
            low_q <= 3'h4;
        end else if (low_q != 3'h0) begin
            low_q <= low_q - 3'h1;
        end
    end
    // Dropping enable while a fault is reported lets the die cool down.
    assign enable_in = (low_q == 3'h0) && !(cool_en && !fault_out_n);
endmodule : trm_ctrl_model

// [verification/trm_fault_manager_tb_top.sv]
// Self-checking testbench for the thermal and rail fault manager.
`timescale 1ns/1ps
`include "trm_regs.svh"
module trm_fault_manager_tb_top
    import trm_pkg::*;
;
    localparam int HIC = 200;
    localparam int SS = 50;
    typedef struct packed {
        logic [1:0] ctl;
        logic w;
        logic sd;
        logic fn;
        logic [5:0] fl;
    } trm_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic enable_in, temp_warn, temp_shutdown, peak, climit, ocur, under, over;
    logic fault_out_n, gate_drive_en, standby_reg_en, standby_sw_on;
    logic run_reg_en, run_sw_on, core_low_power, buck_pwm, pump_a, pump_b;
    logic pulse_req, cool_en;
    int error_cnt, total_checks, cnt, pk;
    trm_row_s rows [5] = '{{2'h0, 1'b1, 1'b0, 1'b1, 6'h01},
        {2'h1, 1'b1, 1'b0, 1'b0, 6'h01}, {2'h1, 1'b0, 1'b0, 1'b1, 6'h00},
        {2'h2, 1'b0, 1'b1, 1'b0, 6'h02}, {2'h2, 1'b0, 1'b0, 1'b1, 6'h02}};

    trm_fault_manager #(.HICCUP_CYCLES(HIC), .SOFTSTART_CYCLES(SS))
        trm_fault_manager_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .enable_in, .temp_warn, .temp_shutdown,
        .buck_peak_reached(peak), .buck_current_limit(climit),
        .buck_overcurrent(ocur), .drive_rail_under(under),
        .drive_rail_over(over), .fault_out_n, .gate_drive_en,
        .standby_reg_en, .standby_sw_on, .run_reg_en, .run_sw_on,
        .core_low_power, .buck_pwm, .pump_a, .pump_b);
    trm_ctrl_model trm_ctrl_model_inst (.pclk, .presetn, .fault_out_n,
        .pulse_req, .cool_en, .enable_in);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // A short peak-current pulse every seventh cycle ends each buck pulse.
    always @(posedge pclk) begin
        pk <= (pk + 1) % 7;
        peak <= (pk == 0);
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wt(input int c);
        repeat (c) @(posedge pclk);
    endtask : wt

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task stat;
        apb(1'b0, `TRM_STAT_OFS, 32'h0);
    endtask : stat

    task clr;
        apb(1'b1, `TRM_CTRL_OFS, 32'h4);
    endtask : clr

    task wait_for(input logic f, input int lim);
        cnt = 0;
        while (cnt < lim && (f ? fault_out_n : run_reg_en) !== 1'b1) begin
            @(posedge pclk);
            cnt++;
        end
        chk("wait limit", cnt < lim, 1'b1);
    endtask : wait_for

    task fin(input string t);
        $display("test %s done", t);
    endtask : fin

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        print_verdict;
    end

    initial begin
        int i, n;
        logic anti;
        {psel, penable, pwrite, paddr, pwdata, pulse_req, cool_en} = '0;
        {temp_warn, temp_shutdown, climit, ocur, under, over, peak} = '0;
        pk = 0;
        presetn = 1'b0;
        wt(3);
        chk("reset pins", {fault_out_n, gate_drive_en, standby_reg_en,
            standby_sw_on, run_reg_en, run_sw_on, core_low_power, buck_pwm,
            pump_a, pump_b}, 10'b1011001000);
        wt(2);
        presetn <= 1'b1;
        apb(1'b0, `TRM_CTRL_OFS, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped", err, 1'b1);
        wait_for(1'b0, 500);
        wt(3);
        chk("rails", {standby_reg_en, standby_sw_on, run_reg_en, run_sw_on,
            core_low_power}, 5'b00110);
        for (i = 0; i < 200 && buck_pwm !== 1'b0; i++) @(posedge pclk);
        for (i = 0; i < 200 && buck_pwm !== 1'b1; i++) @(posedge pclk);
        for (n = 0; n < 200 && buck_pwm !== 1'b0; n++) @(posedge pclk);
        for (; n < 400 && buck_pwm !== 1'b1; n++) @(posedge pclk);
        chk("buck period", n, 80);
        anti = 1'b1;
        for (i = 0; i < 400 && pump_a !== 1'b0; i++) @(posedge pclk);
        for (i = 0; i < 400 && pump_a !== 1'b1; i++) @(posedge pclk);
        for (n = 0; n < 400 && pump_a === 1'b1; n++) begin
            @(posedge pclk);
            if (pump_b !== ~pump_a) anti = 1'b0;
        end
        chk("pump half period", n, 80);
        chk("pump antiphase", anti, 1'b1);
        fin("power up");
        for (i = 0; i < 5; i++) begin
            apb(1'b1, `TRM_CTRL_OFS, {30'h0, rows[i].ctl});
            temp_warn <= rows[i].w;
            temp_shutdown <= rows[i].sd;
            wt(4);
            chk("fault_out_n", fault_out_n, rows[i].fn);
            chk("gate_drive_en", gate_drive_en, 1'b1);
            stat;
            chk("flags", rd[6:1], rows[i].fl);
        end
        clr;
        stat;
        chk("flags cleared", rd[6:0], 7'h0);
        fin("table");
        temp_shutdown <= 1'b1;
        wt(4);
        chk("shutdown", {fault_out_n, gate_drive_en, standby_reg_en,
            run_reg_en, buck_pwm, pump_a, pump_b}, 7'b0010000);
        clr;
        stat;
        chk("shutdown flags kept", rd[2:0], 3'b101);
        temp_shutdown <= 1'b0;
        wait_for(1'b0, 500);
        wt(3);
        chk("rails back", {fault_out_n, gate_drive_en, run_reg_en},
            3'b101);
        pulse_req <= 1'b1;
        wt(1);
        pulse_req <= 1'b0;
        wt(10);
        wait_for(1'b0, 500);
        wt(3);
        stat;
        chk("pulse clear", {gate_drive_en, rd[6:0]}, 8'h80);
        apb(1'b1, `TRM_CTRL_OFS, 32'h2);
        cool_en <= 1'b1;
        temp_shutdown <= 1'b1;
        wt(6);
        chk("enable dropped", {enable_in, core_low_power}, 2'b01);
        temp_shutdown <= 1'b0;
        wt(6);
        cool_en <= 1'b0;
        wait_for(1'b0, 500);
        wt(3);
        stat;
        chk("cooled and cleared", rd[6:0], 7'h0);
        fin("thermal");
        apb(1'b1, `TRM_CTRL_OFS, 32'h0);
        ocur <= 1'b1;
        wt(200);
        chk("oc pins", {fault_out_n, gate_drive_en, run_reg_en, pump_a},
            4'h0);
        stat;
        chk("oc flags", {rd[4:3], rd[0]}, 3'b111);
        ocur <= 1'b0;
        wait_for(1'b1, 2000);
        chk("hiccup span", cnt + 203 >= HIC + SS + 80, 1'b1);
        chk("oc gate held", gate_drive_en, 1'b0);
        clr;
        wt(4);
        stat;
        chk("oc cleared", {gate_drive_en, rd[6:0]}, 8'h80);
        fin("overcurrent");
        for (i = 0; i < 2; i++) begin
            under <= (i == 0);
            over <= (i == 1);
            wt(4);
            chk("rail fault", {fault_out_n, gate_drive_en}, 2'b00);
            chk("run rail", run_reg_en, i[0]);
            chk("switching halted", {buck_pwm, pump_a, pump_b}, 3'h0);
            stat;
            chk("rail flags", {rd[6:5], rd[3], rd[0]},
                i[0] ? 4'b1011 : 4'b0111);
            under <= 1'b0;
            over <= 1'b0;
            wait_for(1'b1, 1000);
            wait_for(1'b0, 1000);
            chk("gate held", gate_drive_en, 1'b0);
            clr;
            wt(4);
            stat;
            chk("rail cleared", {gate_drive_en, rd[6:0]}, 8'h80);
        end
        fin("rails");
        climit <= 1'b1;
        wt(300);
        stat;
        chk("limit silent", {fault_out_n, gate_drive_en, rd[6:0]},
            9'h180);
        climit <= 1'b0;
        fin("limit");
        print_verdict;
    end
endmodule : trm_fault_manager_tb_top
